// >>> fan_pwm_pkg.sv
/*
  constants for the fan pwm duty, frequency and lookup offset registers.
  assumes a 50 MHz system clock and an 8-bit register port from the serial bus.
*/
// Behaviour
// - with direct program clear, duty field is read-only and shows lookup duty.
// - with direct program set, software writes duty and it drives the fan.
// - during spin-up, reading the duty register returns zero.
// - pwm frequency is selected master clock divided by twice frequency field.
// - a frequency field of zero divides as though it held one.
// - unsigned 6-bit offset, one degree per step, is added to lookup thresholds.
// - unused upper bits of frequency, offset and hysteresis registers read zero.
// - 5-bit hysteresis, one degree per step, applies only to the release comparison once above threshold.
package fan_pwm_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] ADDR_DUTY = 8'h4c;
  localparam logic [7:0] ADDR_FREQ = 8'h4d;
  localparam logic [7:0] ADDR_OFFSET = 8'h4e;
  localparam logic [7:0] ADDR_HYST = 8'h4f;
  localparam logic [5:0] RESET_DUTY = 6'h00;
  localparam logic [4:0] RESET_FREQ = 5'h17;
  localparam logic [5:0] RESET_OFFSET = 6'h00;
  localparam logic [4:0] RESET_HYST = 5'h04;
  localparam int DUTY_W = 6;
  localparam int FREQ_W = 5;
  localparam int OFFSET_W = 6;
  localparam int HYST_W = 5;
  localparam logic [4:0] FREQ_MIN = 5'h01;
  // ==========================================================================
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int MCLK_FAST_HZ = 360_000;
  localparam int MCLK_SLOW_HZ = 1_400;
  localparam int FAST_DIV = (CLK_HZ + MCLK_FAST_HZ / 2) / MCLK_FAST_HZ;
  localparam int SLOW_DIV = (CLK_HZ + MCLK_SLOW_HZ / 2) / MCLK_SLOW_HZ;
  localparam int DIV_W = 16;
endpackage

// >>> fan_pwm_regs.sv
/*
  duty value, frequency divider, lookup offset and hysteresis registers with the
  pwm generator and threshold comparison they steer. assumes the serial-bus slave presents one-cycle
  read and write strobes with an 8-bit register address, and that the lookup
  table, spin-up logic and mode bits come in as levels synchronous to clk.
*/
`timescale 1ns/1ps
module fan_pwm_regs
  import fan_pwm_pkg::*;
#(
  parameter int SLOW_DIV_COUNT = SLOW_DIV
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic direct_program,
  input wire logic master_clock_slow,
  input wire logic spinup_active,
  input wire logic [5:0] lut_duty,
  input wire logic [6:0] lut_threshold,
  input wire logic [7:0] remote_temp,
  output logic temp_above,
  output logic pwm_out,
  output logic pwm_oe
);
  // ==========================================================================
  // register file
  logic [DUTY_W-1:0] duty_value_field;
  logic [FREQ_W-1:0] frequency_divider_field;
  logic [OFFSET_W-1:0] lut_temp_offset_field;
  logic [HYST_W-1:0] lut_hysteresis_field;
  logic [DUTY_W-1:0] next_duty_value_field;
  logic [FREQ_W-1:0] next_frequency_divider_field;
  logic [OFFSET_W-1:0] next_lut_temp_offset_field;
  logic [HYST_W-1:0] next_lut_hysteresis_field;
  logic [7:0] next_reg_rdata;
  logic [DUTY_W-1:0] selected_duty;

  always_comb
  begin
    selected_duty = direct_program ? duty_value_field : lut_duty;
    next_duty_value_field = duty_value_field;
    next_frequency_divider_field = frequency_divider_field;
    next_lut_temp_offset_field = lut_temp_offset_field;
    next_lut_hysteresis_field = lut_hysteresis_field;
    next_reg_rdata = reg_rdata;
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_DUTY: if (direct_program) next_duty_value_field = reg_wdata[DUTY_W-1:0];
        ADDR_FREQ: next_frequency_divider_field = reg_wdata[FREQ_W-1:0];
        // no sign bit is kept, so a value meant as negative wraps to a large offset
        ADDR_OFFSET: next_lut_temp_offset_field = reg_wdata[OFFSET_W-1:0];
        ADDR_HYST: next_lut_hysteresis_field = reg_wdata[HYST_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_DUTY: next_reg_rdata = spinup_active ? 8'h00 : {2'h0, selected_duty};
        ADDR_FREQ: next_reg_rdata = {3'h0, frequency_divider_field};
        ADDR_OFFSET: next_reg_rdata = {2'h0, lut_temp_offset_field};
        ADDR_HYST: next_reg_rdata = {3'h0, lut_hysteresis_field};
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      duty_value_field <= RESET_DUTY;
      frequency_divider_field <= RESET_FREQ;
      lut_temp_offset_field <= RESET_OFFSET;
      lut_hysteresis_field <= RESET_HYST;
      reg_rdata <= 8'h00;
    end
    else
    begin
      duty_value_field <= next_duty_value_field;
      frequency_divider_field <= next_frequency_divider_field;
      lut_temp_offset_field <= next_lut_temp_offset_field;
      lut_hysteresis_field <= next_lut_hysteresis_field;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ==========================================================================
  // threshold comparison with offset and hysteresis
  logic [8:0] threshold_eff;
  logic [8:0] temp_plus_hyst;
  logic next_temp_above;

  always_comb
  begin
    threshold_eff = {2'h0, lut_threshold} + {3'h0, lut_temp_offset_field};
    // hysteresis is added to the reading so the lower bound can never underflow
    temp_plus_hyst = {1'h0, remote_temp} + {4'h0, lut_hysteresis_field};
    if (!temp_above)
      next_temp_above = {1'h0, remote_temp} > threshold_eff;
    else
      next_temp_above = temp_plus_hyst > threshold_eff;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      temp_above <= 1'b0;
    else
      temp_above <= next_temp_above;
  end

  // ==========================================================================
  // master clock enable, period counter and output
  logic [DIV_W-1:0] mclk_count;
  logic [DIV_W-1:0] next_mclk_count;
  logic [DIV_W-1:0] mclk_limit;
  logic mclk_en;
  logic [FREQ_W:0] period_count;
  logic [FREQ_W:0] next_period_count;
  logic [FREQ_W-1:0] active_n;
  logic [FREQ_W-1:0] next_active_n;
  logic [DUTY_W-1:0] active_duty;
  logic [DUTY_W-1:0] next_active_duty;
  logic period_last;
  logic next_pwm_oe;

  always_comb
  begin
    mclk_limit = master_clock_slow ? DIV_W'(SLOW_DIV_COUNT - 1) : DIV_W'(FAST_DIV - 1);
    mclk_en = (mclk_count >= mclk_limit);
    next_mclk_count = mclk_en ? '0 : mclk_count + 1'b1;
    period_last = (period_count >= {active_n, 1'b0} - 1'b1);
    next_period_count = period_count;
    next_active_n = active_n;
    next_active_duty = active_duty;
    if (mclk_en)
    begin
      if (period_last)
      begin
        next_period_count = '0;
        // new settings wait for the boundary so no pulse is cut short
        next_active_duty = selected_duty;
        next_active_n = (frequency_divider_field == '0) ? FREQ_MIN : frequency_divider_field;
      end
      else
        next_period_count = period_count + 1'b1;
    end
    // high for duty/64 of the period: count/(2n) < duty/64
    next_pwm_oe = !(({6'h0, next_period_count} << 5) < (12'(next_active_duty) * 12'(next_active_n)));
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mclk_count <= '0;
      period_count <= '0;
      active_n <= RESET_FREQ;
      active_duty <= RESET_DUTY;
      pwm_oe <= 1'b1;
      pwm_out <= 1'b0;
    end
    else
    begin
      mclk_count <= next_mclk_count;
      period_count <= next_period_count;
      active_n <= next_active_n;
      active_duty <= next_active_duty;
      pwm_oe <= next_pwm_oe;
      pwm_out <= 1'b0;
    end
  end

  // ==========================================================================
  // assertions
  // helper: clocks since the last master tick, and whether the fast clock held all that time
  logic [DIV_W-1:0] gap_count;
  logic [DIV_W-1:0] next_gap_count;
  logic fast_run;
  logic next_fast_run;

  always_comb
  begin
    next_gap_count = gap_count + 1'b1;
    next_fast_run = fast_run && !master_clock_slow;
    if (mclk_en)
    begin
      next_gap_count = '0;
      next_fast_run = !master_clock_slow;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gap_count <= '0;
      fast_run <= 1'h0;
    end
    else
    begin
      gap_count <= next_gap_count;
      fast_run <= next_fast_run;
    end
  end

  sequence duty_write_s;
    reg_wr && reg_addr == ADDR_DUTY;
  endsequence

  sequence duty_read_spin_s;
    reg_rd && reg_addr == ADDR_DUTY && spinup_active;
  endsequence

  a_duty_read_only: assert property (@(posedge clk) disable iff (!rst_n)
    duty_write_s ##0 !direct_program |=> duty_value_field == $past(duty_value_field))
    else $error("duty field changed while read-only");
  a_duty_lut_read: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_DUTY && !spinup_active && !direct_program
    |=> reg_rdata == {2'h0, $past(lut_duty)})
    else $error("duty read does not show lookup value");
  a_duty_sw_write: assert property (@(posedge clk) disable iff (!rst_n)
    duty_write_s ##0 direct_program |=> duty_value_field == $past(reg_wdata[5:0]))
    else $error("direct duty write lost");
  a_spin_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
    duty_read_spin_s |=> reg_rdata == 8'h00)
    else $error("duty read nonzero during spin-up");
  a_freq_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && (reg_addr == ADDR_FREQ || reg_addr == ADDR_HYST) |=> reg_rdata[7:5] == 3'h0)
    else $error("reserved bits nonzero");
  a_offset_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_OFFSET |=> reg_rdata[7:6] == 2'h0)
    else $error("offset reserved bits nonzero");
  a_divisor_nonzero: assert property (@(posedge clk) disable iff (!rst_n)
    active_n != '0 && period_count < {active_n, 1'b0})
    else $error("zero divisor or period overrun");
  a_period_boundary: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(active_duty) || $changed(active_n) |-> $past(mclk_en && period_last))
    else $error("settings changed mid-period");
  a_mclk_rate: assert property (@(posedge clk) disable iff (!rst_n)
    mclk_en && fast_run && !master_clock_slow |-> gap_count == DIV_W'(FAST_DIV - 1))
    else $error("fast master tick came early");
  a_mclk_late: assert property (@(posedge clk) disable iff (!rst_n)
    fast_run && !master_clock_slow && gap_count >= DIV_W'(FAST_DIV - 1) |-> mclk_en)
    else $error("fast master tick came late");
  a_above_set: assert property (@(posedge clk) disable iff (!rst_n)
    !temp_above && {1'h0, remote_temp} > {2'h0, lut_threshold} + {3'h0, lut_temp_offset_field}
    |=> temp_above)
    else $error("threshold crossing missed");
  a_hyst_hold: assert property (@(posedge clk) disable iff (!rst_n)
    temp_above && ({1'h0, remote_temp} + {4'h0, lut_hysteresis_field})
    > ({2'h0, lut_threshold} + {3'h0, lut_temp_offset_field}) |=> temp_above)
    else $error("released inside hysteresis band");
  a_hyst_release: assert property (@(posedge clk) disable iff (!rst_n)
    temp_above && ({1'h0, remote_temp} + {4'h0, lut_hysteresis_field})
    <= ({2'h0, lut_threshold} + {3'h0, lut_temp_offset_field}) |=> !temp_above)
    else $error("not released below hysteresis band");
endmodule

// >>> fan_model.sv
/*
  four-pin fan input seen through the open-drain pwm pin, with a pull-up.
  assumes pwm_oe high means the pin is pulled low and that clk is the system clock.
*/
`timescale 1ns/1ps
module fan_model
(
  input wire logic clk,
  input wire logic pwm_oe,
  input wire logic pwm_out,
  output logic pin,
  output logic [15:0] period,
  output logic [15:0] high_time
);
  logic prev;
  logic [15:0] cnt;
  logic [15:0] hcnt;
  // ==========================================================================
  // pin level: a released pin floats up to the pull-up, never the last value
  assign pin = pwm_oe ? pwm_out : 1'b1;
  // ==========================================================================
  // period and high time, measured from one rising edge to the next
  initial prev = 1'b1;
  always @(posedge clk)
  begin
    prev <= pin;
    if (pin && !prev)
    begin
      period <= cnt;
      high_time <= hcnt;
      cnt <= 16'h0001;
      hcnt <= 16'h0001;
    end
    else
    begin
      cnt <= cnt + 16'h0001;
      hcnt <= hcnt + {15'h0000, pin};
    end
  end
endmodule

// >>> fan_pwm_value_frequency_regs_tb_top.sv
/*
  self-checking bench for the duty, frequency, offset and hysteresis registers.
  assumes the fan model above on the pin and a short slow master divider.
*/
`timescale 1ns/1ps
module fan_pwm_value_frequency_regs_tb_top;
  import fan_pwm_pkg::*;
  localparam int SDIV = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic direct_program = 1'b0;
  logic master_clock_slow = 1'b1;
  logic spinup_active = 1'b0;
  logic [5:0] lut_duty = 6'h00;
  logic [6:0] lut_threshold = 7'h64;
  logic [7:0] remote_temp = 8'h00;
  logic temp_above;
  logic pwm_out;
  logic pwm_oe;
  logic pin;
  logic [15:0] period;
  logic [15:0] high_time;
  int failures = 0;
  int cmp_count = 0;
  always #10 clk = ~clk;
  fan_pwm_regs #(.SLOW_DIV_COUNT(SDIV)) DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .direct_program(direct_program), .master_clock_slow(master_clock_slow),
    .spinup_active(spinup_active), .lut_duty(lut_duty), .lut_threshold(lut_threshold),
    .remote_temp(remote_temp), .temp_above(temp_above), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
  fan_model fan (.clk(clk), .pwm_oe(pwm_oe), .pwm_out(pwm_out), .pin(pin), .period(period),
    .high_time(high_time));
  // ==========================================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic temp(input logic [7:0] t, input logic exp);
    @(posedge clk);
    remote_temp <= t;
    repeat (2) @(posedge clk);
    chk({15'h0000, temp_above}, {15'h0000, exp});
  endtask
  task automatic pwm(input int wait_clks, input int per, input int hi);
    repeat (wait_clks) @(posedge clk);
    chk(period, per[15:0]);
    chk(high_time, hi[15:0]);
  endtask
  task automatic finish_test;
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================================
  // tests
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_DUTY, 8'h00);
    rd(ADDR_FREQ, 8'h17);
    rd(ADDR_OFFSET, 8'h00);
    rd(ADDR_HYST, 8'h04);
    wr(ADDR_FREQ, 8'hff);
    rd(ADDR_FREQ, 8'h1f);
    wr(ADDR_OFFSET, 8'hff);
    rd(ADDR_OFFSET, 8'h3f);
    wr(ADDR_HYST, 8'hff);
    rd(ADDR_HYST, 8'h1f);
    rd(8'h40, 8'h00);
    lut_duty <= 6'h2a;
    wr(ADDR_DUTY, 8'h11);
    rd(ADDR_DUTY, 8'h2a);
    direct_program <= 1'b1;
    rd(ADDR_DUTY, 8'h00);
    wr(ADDR_DUTY, 8'h11);
    rd(ADDR_DUTY, 8'h11);
    spinup_active <= 1'b1;
    rd(ADDR_DUTY, 8'h00);
    spinup_active <= 1'b0;
    wr(ADDR_OFFSET, 8'h1e);
    temp(8'd131, 1'b1);
    temp(8'd100, 1'b1);
    temp(8'd99, 1'b0);
    lut_threshold <= 7'h7f;
    wr(ADDR_OFFSET, 8'h3f);
    temp(8'd190, 1'b0);
    temp(8'd191, 1'b1);
    wr(ADDR_DUTY, 8'h20);
    wr(ADDR_FREQ, 8'h02);
    pwm(2000, 4 * SDIV, 2 * SDIV);
    wr(ADDR_FREQ, 8'h00);
    pwm(400, 2 * SDIV, SDIV);
    master_clock_slow <= 1'b0;
    wr(ADDR_FREQ, 8'h01);
    pwm(1200, 2 * FAST_DIV, FAST_DIV);
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule
